// ### hdl/crf_pkg.sv
`default_nettype none
package crf_pkg;

   // register word offsets on the bus
   localparam logic [7:0] CRF_OFF_PC    = 8'h00;
   localparam logic [7:0] CRF_OFF_ACC   = 8'h04;
   localparam logic [7:0] CRF_OFF_TMP   = 8'h08;
   localparam logic [7:0] CRF_OFF_INDEX = 8'h0C;
   localparam logic [7:0] CRF_OFF_XPTR  = 8'h10;
   localparam logic [7:0] CRF_OFF_SP    = 8'h14;
   localparam logic [7:0] CRF_OFF_PSW   = 8'h18;
   localparam logic [7:0] CRF_OFF_ALU   = 8'h1C;
   localparam logic [7:0] CRF_OFF_GPR   = 8'h20;
   localparam logic [7:0] CRF_OFF_PROBE = 8'h24;

   // condition code byte bit positions
   localparam int CRF_BIT_C   = 0;
   localparam int CRF_BIT_V   = 1;
   localparam int CRF_BIT_Z   = 2;
   localparam int CRF_BIT_N   = 3;
   localparam int CRF_BIT_LVL_LO = 4;
   localparam int CRF_BIT_LVL_HI = 5;
   localparam int CRF_BIT_I   = 6;
   localparam int CRF_BIT_H   = 7;

   // alu command fields
   localparam int CRF_ALU_WORD_BIT = 3;

   // reset values
   localparam logic [15:0] CRF_RST_PSW  = 16'h0030;
   localparam logic [15:0] CRF_RST_WORD = 16'h0000;

   // memory layout of the 64 Kbyte space
   localparam logic [16:0] CRF_MEM_SIZE   = 17'h10000;
   localparam logic [15:0] CRF_IO_END     = 16'h0080;
   localparam logic [15:0] CRF_PROG_BASE  = 16'h4000;
   localparam logic [15:0] CRF_BANK_BASE  = 16'h0100;
   localparam int          CRF_BANK_REGS  = 8;
   localparam int          CRF_BANK_COUNT = 16;

   typedef enum logic [2:0]
   {
      CRF_OP_ADD = 3'b000,
      CRF_OP_SUB = 3'b001,
      CRF_OP_SHL = 3'b010,
      CRF_OP_SHR = 3'b011
   } crf_op_t;

   typedef enum logic [1:0]
   {
      CRF_REG_IO   = 2'b00,
      CRF_REG_DATA = 2'b01,
      CRF_REG_PROG = 2'b10
   } crf_region_t;

   typedef struct packed
   {
      logic h;
      logic n;
      logic z;
      logic v;
      logic c;
   } crf_flags_t;

endpackage
`default_nettype wire

// ### hdl/crf_alu.sv
`default_nettype none
module crf_alu
   import crf_pkg::*;
(
   input  wire logic [15:0] acc,
   input  wire logic [15:0] tmp,
   input  wire crf_op_t     op,
   input  wire logic        word,
   output logic      [15:0] result,
   output crf_flags_t       flags,
   output logic             hv_upd
);

   wire  [8:0]  add_lo  = {1'b0, acc[7:0]} + {1'b0, tmp[7:0]};
   wire  [8:0]  sub_lo  = {1'b0, acc[7:0]} - {1'b0, tmp[7:0]};
   wire  [16:0] add_w   = {1'b0, acc} + {1'b0, tmp};
   wire  [16:0] sub_w   = {1'b0, acc} - {1'b0, tmp};
   wire  [4:0]  add_nib = {1'b0, acc[3:0]} + {1'b0, tmp[3:0]};
   wire  [4:0]  sub_nib = {1'b0, acc[3:0]} - {1'b0, tmp[3:0]};
   wire         msb_a   = word ? acc[15] : acc[7];
   wire         msb_t   = word ? tmp[15] : tmp[7];
   logic [15:0] raw;
   logic        cout;
   wire         msb_r   = word ? raw[15] : raw[7];

   // operation and carry out of bit 7 (bit 15 for word ops); bit 0 for shift right
   always_comb
   begin
      raw  = 16'h0000;
      cout = 1'b0;
      unique case (op)
         CRF_OP_ADD:
         begin
            raw  = word ? add_w[15:0] : {8'h00, add_lo[7:0]};
            cout = word ? add_w[16] : add_lo[8];
         end
         CRF_OP_SUB:
         begin
            raw  = word ? sub_w[15:0] : {8'h00, sub_lo[7:0]};
            cout = word ? sub_w[16] : sub_lo[8];
         end
         CRF_OP_SHL:
         begin
            raw  = {acc[14:0], 1'b0};
            cout = msb_a;
         end
         CRF_OP_SHR:
         begin
            raw  = word ? {1'b0, acc[15:1]} : {9'h000, acc[7:1]};
            cout = acc[0];
         end
      endcase
   end

   // byte ops leave the upper accumulator byte alone
   assign result  = word ? raw : {acc[15:8], raw[7:0]};
   assign hv_upd  = (op == CRF_OP_ADD) || (op == CRF_OP_SUB);
   assign flags.h = (op == CRF_OP_ADD) ? add_nib[4] : sub_nib[4];
   assign flags.n = msb_r;
   assign flags.z = word ? (raw == 16'h0000) : (raw[7:0] == 8'h00);
   assign flags.v = (op == CRF_OP_ADD) ? ((msb_a == msb_t) && (msb_r != msb_a))
                                       : ((msb_a != msb_t) && (msb_r != msb_a));
   assign flags.c = cout;

endmodule // crf_alu
`default_nettype wire

// ### hdl/crf_core_regs.sv
// Implementation choices: the address map and the APB interface to the registers.
`default_nettype none
// Overview of operation
// - one 64 Kbyte space: I/O lowest, data above, program at the top
// - program counter, index, extra pointer and stack pointer are 16 bits
// - accumulator and temporary are 16 bits; byte ops use the low byte
// - status word: upper byte bank pointer, lower byte condition codes
// - half-carry set on carry or borrow between bits 3 and 4
// - interrupt enable 1 allows, 0 blocks; reset clears it
// - two-bit level mask; only request levels below the mask serviced; 00 blocks all
// - negative flag follows the result msb
// - zero flag set when the result is zero
// - overflow flag set on two's complement overflow
// - carry from bit 7 (bit 15 for word ops) in arithmetic; shifted-out bit for shifts
// - eight-bit general registers in banks of eight, sixteen banks, pointer selects
module crf_core_regs
   import crf_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              irq_req,
   input  wire logic [1:0]        irq_level,
   output logic                   irq_take,
   output logic      [15:0]       gpr_addr,
   output crf_region_t            mem_region
);

   // elaboration check on the address width
   if (ADDR_W < 8)
   begin : g_bad_addr
      $error("crf_core_regs: ADDR_W must be at least 8");
   end

   logic [15:0]  pc_ff;
   logic [15:0]  acc_ff;
   logic [15:0]  tmp_ff;
   logic [15:0]  idx_ff;
   logic [15:0]  xptr_ff;
   logic [15:0]  sp_ff;
   logic [15:0]  psw_ff;
   logic [2:0]   gpr_num_ff;
   logic [15:0]  probe_ff;
   logic [31:0]  prdata_ff;
   logic         pready_ff;
   logic         pslverr_ff;
   logic         irq_take_ff;
   logic [15:0]  gpr_addr_ff;
   crf_region_t  region_ff;

   // bus phase decode
   wire          setup_ph = psel && !penable;
   wire          wr_done  = psel && penable && pready_ff && pwrite;
   wire  [7:0]   off      = paddr[7:0];
   wire          hi_zero  = (paddr >> 8) == '0;
   wire          sel_pc   = hi_zero && (off == CRF_OFF_PC);
   wire          sel_acc  = hi_zero && (off == CRF_OFF_ACC);
   wire          sel_tmp  = hi_zero && (off == CRF_OFF_TMP);
   wire          sel_idx  = hi_zero && (off == CRF_OFF_INDEX);
   wire          sel_xp   = hi_zero && (off == CRF_OFF_XPTR);
   wire          sel_sp   = hi_zero && (off == CRF_OFF_SP);
   wire          sel_psw  = hi_zero && (off == CRF_OFF_PSW);
   wire          sel_alu  = hi_zero && (off == CRF_OFF_ALU);
   wire          sel_gpr  = hi_zero && (off == CRF_OFF_GPR);
   wire          sel_prb  = hi_zero && (off == CRF_OFF_PROBE);
   wire          mapped   = sel_pc || sel_acc || sel_tmp || sel_idx || sel_xp
                            || sel_sp || sel_psw || sel_alu || sel_gpr || sel_prb;

   // byte-lane merge for 16-bit registers
   function automatic logic [15:0] lane16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
      lane16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction

   // alu command decode; only the four defined ops are legal
   wire  [2:0]   op_raw   = pwdata[2:0];
   wire          op_legal = (op_raw == CRF_OP_ADD) || (op_raw == CRF_OP_SUB)
                            || (op_raw == CRF_OP_SHL) || (op_raw == CRF_OP_SHR);
   wire          alu_go   = wr_done && sel_alu && pstrb[0] && op_legal;
   wire          bad_wr   = pwrite && sel_alu && !op_legal;
   crf_op_t      alu_op;
   logic [15:0]  alu_res;
   crf_flags_t   alu_flg;
   logic         alu_hv;

   assign alu_op = crf_op_t'(op_raw);

   // arithmetic on accumulator and temporary
   crf_alu u_alu
   (
      .acc    (acc_ff),
      .tmp    (tmp_ff),
      .op     (alu_op),
      .word   (pwdata[CRF_ALU_WORD_BIT]),
      .result (alu_res),
      .flags  (alu_flg),
      .hv_upd (alu_hv)
   );

   // condition code update from the alu
   wire  [7:0]   ccr_old = psw_ff[7:0];
   logic [7:0]   ccr_alu;
   always_comb
   begin
      ccr_alu            = ccr_old;
      ccr_alu[CRF_BIT_C] = alu_flg.c;
      ccr_alu[CRF_BIT_N] = alu_flg.n;
      ccr_alu[CRF_BIT_Z] = alu_flg.z;
      if (alu_hv)
      begin
         ccr_alu[CRF_BIT_H] = alu_flg.h;
         ccr_alu[CRF_BIT_V] = alu_flg.v;
      end
   end

   // next values of the dedicated registers
   wire  [15:0]  nxt_pc  = (wr_done && sel_pc) ? lane16(pc_ff, pwdata, pstrb) : pc_ff;
   wire  [15:0]  nxt_idx  = (wr_done && sel_idx) ? lane16(idx_ff, pwdata, pstrb) : idx_ff;
   wire  [15:0]  nxt_xptr = (wr_done && sel_xp) ? lane16(xptr_ff, pwdata, pstrb) : xptr_ff;
   wire  [15:0]  nxt_sp  = (wr_done && sel_sp) ? lane16(sp_ff, pwdata, pstrb) : sp_ff;
   wire  [15:0]  nxt_tmp = (wr_done && sel_tmp) ? lane16(tmp_ff, pwdata, pstrb) : tmp_ff;
   wire  [15:0]  nxt_acc = alu_go ? alu_res
                         : (wr_done && sel_acc) ? lane16(acc_ff, pwdata, pstrb) : acc_ff;
   wire  [15:0]  nxt_psw = alu_go ? {psw_ff[15:8], ccr_alu}
                         : (wr_done && sel_psw) ? lane16(psw_ff, pwdata, pstrb) : psw_ff;
   wire  [2:0]   nxt_gpr_num = (wr_done && sel_gpr && pstrb[0]) ? pwdata[2:0] : gpr_num_ff;
   wire  [15:0]  nxt_probe   = (wr_done && sel_prb) ? lane16(probe_ff, pwdata, pstrb)
                                                    : probe_ff;

   // pc, index, extra pointer, stack pointer, accumulator, temporary
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc_ff  <= CRF_RST_WORD;
         idx_ff  <= CRF_RST_WORD;
         xptr_ff <= CRF_RST_WORD;
         sp_ff  <= CRF_RST_WORD;
         acc_ff <= CRF_RST_WORD;
         tmp_ff <= CRF_RST_WORD;
      end
      else
      begin
         pc_ff  <= nxt_pc;
         idx_ff  <= nxt_idx;
         xptr_ff <= nxt_xptr;
         sp_ff  <= nxt_sp;
         acc_ff <= nxt_acc;
         tmp_ff <= nxt_tmp;
      end
   end

   // status word; reset clears interrupt enable, mask at 11
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         psw_ff <= CRF_RST_PSW;
      end
      else
      begin
         psw_ff <= nxt_psw;
      end
   end

   // register select and probe address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gpr_num_ff <= 3'h0;
         probe_ff   <= CRF_RST_WORD;
      end
      else
      begin
         gpr_num_ff <= nxt_gpr_num;
         probe_ff   <= nxt_probe;
      end
   end

   // general register address from bank pointer and number
   wire  [3:0]   bank_ptr  = psw_ff[11:8];
   wire  [15:0]  nxt_gaddr = CRF_BANK_BASE + {9'h000, bank_ptr, gpr_num_ff};

   // region of the probed address in the 64 Kbyte space
   crf_region_t  nxt_region;
   assign nxt_region = (probe_ff < CRF_IO_END)    ? CRF_REG_IO
                     : (probe_ff < CRF_PROG_BASE) ? CRF_REG_DATA
                                                  : CRF_REG_PROG;

   // interrupt acceptance: enabled and level below the mask
   wire  [1:0]   il_mask   = {psw_ff[CRF_BIT_LVL_HI], psw_ff[CRF_BIT_LVL_LO]};
   wire          nxt_take  = psw_ff[CRF_BIT_I] && irq_req
                             && (irq_level < il_mask);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_take_ff <= 1'b0;
         gpr_addr_ff <= CRF_BANK_BASE;
         region_ff   <= CRF_REG_IO;
      end
      else
      begin
         irq_take_ff <= nxt_take;
         gpr_addr_ff <= nxt_gaddr;
         region_ff   <= nxt_region;
      end
   end

   // read mux, upper bits read as zero
   logic [15:0]  rd_val;
   always_comb
   begin
      rd_val = 16'h0000;
      if (sel_pc)  rd_val = pc_ff;
      if (sel_acc) rd_val = acc_ff;
      if (sel_tmp) rd_val = tmp_ff;
      if (sel_idx) rd_val = idx_ff;
      if (sel_xp)  rd_val = xptr_ff;
      if (sel_sp)  rd_val = sp_ff;
      if (sel_psw) rd_val = psw_ff;
      if (sel_gpr) rd_val = nxt_gaddr;
      if (sel_prb) rd_val = {14'h0000, nxt_region};
   end

   // no wait state: answer captured in the setup cycle, pready high in the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff  <= setup_ph;
         pslverr_ff <= setup_ph && (!mapped || bad_wr);
         if (setup_ph && !pwrite)
         begin
            prdata_ff <= {16'h0000, rd_val};
         end
      end
   end

   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign irq_take   = irq_take_ff;
   assign gpr_addr   = gpr_addr_ff;
   assign mem_region = region_ff;

endmodule // crf_core_regs
`default_nettype wire

// ### test/crf_core_regs_assertions.sv
`default_nettype none
module crf_core_regs_chk
   import crf_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              irq_req,
   input wire logic [1:0]        irq_level,
   input wire logic              irq_take,
   input wire logic [15:0]       gpr_addr,
   input wire crf_region_t       mem_region
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // bus phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence

   // handshake timing
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_ready_one_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_has_cause: assert property (pready |-> psel && penable)
      else $error("pready without access");
   // address decode
   a_unmapped_error: assert property (s_done ##0 (paddr > 'h24 && paddr[1:0] == 2'b00) |-> pslverr)
      else $error("unmapped access not refused");
   a_mapped_read_ok: assert property (s_done ##0 (!pwrite && paddr <= 'h24 && paddr[1:0] == 2'b00)
      |-> !pslverr) else $error("mapped read refused");
   // read data shape
   a_read_upper_zero: assert property (s_done ##0 !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_alu_reads_zero: assert property (s_done ##0 (!pwrite && paddr == CRF_OFF_ALU) |-> prdata == 32'h0)
      else $error("alu command read not zero");
   // side outputs
   a_gpr_window: assert property (gpr_addr[15:7] == 9'h002)
      else $error("register address outside bank area");
   a_irq_cause: assert property (irq_take |-> $past(irq_req) && $past(irq_level) != 2'b11)
      else $error("interrupt taken without valid request");
   a_region_legal: assert property (mem_region != 2'b11)
      else $error("illegal region code");
endmodule // crf_core_regs_chk

bind crf_core_regs crf_core_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
   .irq_level(irq_level), .irq_take(irq_take), .gpr_addr(gpr_addr), .mem_region(mem_region));
`default_nettype wire

// ### test/crf_core_regs_tb.sv
`default_nettype none
module crf_core_regs_tb
   import crf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, irq_req, pready, pslverr, irq_take;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  pstrb;
   logic [1:0]  irq_level;
   logic [15:0] gpr_addr;
   crf_region_t mem_region;
   logic        e;
   int          bad_count, checks_done, cyc;

   crf_core_regs #(.ADDR_W(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
      .irq_level(irq_level), .irq_take(irq_take), .gpr_addr(gpr_addr), .mem_region(mem_region));

   // clock source
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer, held until pready seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for the edge at which pready is sampled high
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         bad_count++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF, r, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'hF, r, e);
      chk(r, exp);
   endtask

   task automatic irq_chk(input logic q, input logic [1:0] l, input logic exp);
      @(posedge pclk);
      irq_req   <= q;
      irq_level <= l;
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, irq_take}, {31'h0, exp});
   endtask

   task automatic t_reset();
      rd_chk(CRF_OFF_PSW, 32'h0000_0030);
      for (int i = 0; i < 6; i++)
         rd_chk(8'(i * 4), 32'h0);
      chk({16'h0, gpr_addr}, 32'h0000_0100);
      $display("test reset done");
   endtask

   task automatic t_width();
      for (int i = 0; i < 6; i++)
      begin
         wr(8'(i * 4), 32'hFFFF_FFFF);
         rd_chk(8'(i * 4), 32'h0000_FFFF);
      end
      apb(1'b1, CRF_OFF_INDEX, 32'h0000_1234, 4'h1, r, e);
      rd_chk(CRF_OFF_INDEX, 32'h0000_FF34);
      $display("test width done");
   endtask

   task automatic t_alu();
      logic [59:0] tb_row [9];
      tb_row = '{60'h120F_0001_0_1210_B0, 60'h127F_0001_0_1280_BA, 60'h12FF_0001_0_1200_B5,
                 60'h1200_0001_1_12FF_B9, 60'h1280_0001_1_127F_B2, 60'h1281_0000_2_1202_31,
                 60'h1201_0000_3_1200_35, 60'hFFFF_0001_8_0000_B5, 60'h8000_0001_9_7FFF_B2};
      foreach (tb_row[i])
      begin
         wr(CRF_OFF_PSW, 32'h0000_0030);
         wr(CRF_OFF_ACC, {16'h0, tb_row[i][59:44]});
         wr(CRF_OFF_TMP, {16'h0, tb_row[i][43:28]});
         wr(CRF_OFF_ALU, {28'h0, tb_row[i][27:24]});
         rd_chk(CRF_OFF_ACC, {16'h0, tb_row[i][23:8]});
         rd_chk(CRF_OFF_PSW, {24'h0, tb_row[i][7:0]});
      end
      apb(1'b1, CRF_OFF_ALU, 32'h0000_0004, 4'hF, r, e);
      chk({31'h0, e}, 32'h1);
      rd_chk(CRF_OFF_ACC, 32'h0000_7FFF);
      $display("test alu done");
   endtask

   task automatic t_irq();
      wr(CRF_OFF_PSW, 32'h0000_0000);
      irq_chk(1'b1, 2'b00, 1'b0);
      wr(CRF_OFF_PSW, 32'h0000_0060);
      irq_chk(1'b1, 2'b01, 1'b1);
      irq_chk(1'b1, 2'b10, 1'b0);
      irq_chk(1'b0, 2'b00, 1'b0);
      wr(CRF_OFF_PSW, 32'h0000_0070);
      irq_chk(1'b1, 2'b11, 1'b0);
      irq_chk(1'b1, 2'b10, 1'b1);
      // second reset while a request is pending
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      irq_chk(1'b1, 2'b00, 1'b0);
      rd_chk(CRF_OFF_PSW, 32'h0000_0030);
      $display("test irq done");
   endtask

   task automatic t_gpr();
      wr(CRF_OFF_PSW, 32'h0000_0F30);
      rd_chk(CRF_OFF_PSW, 32'h0000_0F30);
      wr(CRF_OFF_GPR, 32'h0000_0005);
      rd_chk(CRF_OFF_GPR, 32'h0000_017D);
      chk({16'h0, gpr_addr}, 32'h0000_017D);
      wr(CRF_OFF_PSW, 32'h0000_0030);
      wr(CRF_OFF_GPR, 32'h0000_0000);
      rd_chk(CRF_OFF_GPR, 32'h0000_0100);
      $display("test gpr done");
   endtask

   task automatic t_region();
      logic [15:0] pa [5];
      logic [1:0]  rc [5];
      pa = '{16'h007F, 16'h0080, 16'h3FFF, 16'h4000, 16'hFFFF};
      rc = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2};
      foreach (pa[i])
      begin
         wr(CRF_OFF_PROBE, {16'h0, pa[i]});
         rd_chk(CRF_OFF_PROBE, {30'h0, rc[i]});
         chk({30'h0, mem_region}, {30'h0, rc[i]});
      end
      apb(1'b0, 8'h28, 32'h0, 4'hF, r, e);
      chk({31'h0, e}, 32'h1);
      $display("test region done");
   endtask

   // main sequence
   initial
   begin
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      pstrb     = 4'h0;
      irq_req   = 1'b0;
      irq_level = 2'b00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_width();
      t_alu();
      t_irq();
      t_gpr();
      t_region();
      end_of_test();
   end
endmodule // crf_core_regs_tb
`default_nettype wire
